//--- verilog/ufbt_pkg.sv
package ufbt_pkg;
  // Byte-wide register map
  localparam logic [7:0] FD_OFF = 8'h9d;
  localparam logic [7:0] CTRL_OFF = 8'h9e;
  localparam logic [7:0] FD_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Field positions
  localparam int CTRL_SEL_BIT = 7;
  localparam int CTRL_DIV_MSB = 2;
  localparam int FD_MSB = 5;
  localparam int DIV_W = 3;
  localparam int FD_W = 6;
  // Highest documented prescale exponent
  localparam logic [2:0] DIV_MAX = 3'h6;
  // Accumulator width of 13 bits, and tick weight per clock
  localparam int ACC_W = 13;
  localparam logic [ACC_W-1:0] ACC_STEP = 13'h0040;
  // Reference setting: control 81H, fraction 2DH
  localparam logic [2:0] EX_DIV = 3'h1;
  localparam logic [5:0] EX_FD = 6'h2d;
  localparam logic [ACC_W-1:0] EX_MOD = 13'h00da;
  // Fixed-rate serial mode counter end value: a tick every 4 clocks at single rate
  localparam logic [1:0] FIX_LAST = 2'h3;
endpackage : ufbt_pkg

//--- verilog/ufbt_div_if.sv
interface ufbt_div_if;
  logic run;
  logic restart;
  logic [ufbt_pkg::ACC_W-1:0] modulus;
  logic tick;
  modport ctrl (output run, output restart, output modulus, input tick);
  modport div (input run, input restart, input modulus, output tick);
endinterface : ufbt_div_if

//--- verilog/ufbt_frac_div.sv
module ufbt_frac_div (
  input wire logic clock,
  input wire logic rst,
  ufbt_div_if.div bus
);
  logic [ufbt_pkg::ACC_W-1:0] acc;
  logic [ufbt_pkg::ACC_W:0] sum;
  logic wrap;
  logic [ufbt_pkg::ACC_W-1:0] next_acc;

  // Adds 64 per clock, wraps at 2^div*(fd+64)
  assign sum = {1'b0, acc} + {1'b0, ufbt_pkg::ACC_STEP};
  assign wrap = sum >= {1'b0, bus.modulus};
  assign next_acc = wrap ? ufbt_pkg::ACC_W'(sum - {1'b0, bus.modulus})
                         : ufbt_pkg::ACC_W'(sum);

  // Restart on reconfiguration so no stale residue bursts ticks
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      acc <= '0;
      bus.tick <= 1'b0;
    end
    else if (!bus.run || bus.restart)
    begin
      acc <= '0;
      bus.tick <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      bus.tick <= wrap;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_acc_bound: assert property (bus.run && !bus.restart
    && $stable(bus.modulus) |=> acc < bus.modulus)
    else $error("accumulator passed modulus");
endmodule : ufbt_frac_div

//--- verilog/ufbt_top.sv
// Function
// - Select bit makes timer the rate source
// - Selected: ignore double-rate and timer2 selects
// - Deselected: classic fixed, timer1, timer2 sources
// - Exponent field picks binary divider 0..6
// - Six-bit fraction sets fractional ratio
// - Unimplemented bits ignored, read as zero
// - Control register at 9EH resets to zero
// - Fraction register at 9DH resets zero
// - 81H with 2DH gives about 230400
// - Rate is 2f over 2^(div-1)(fd+64)
// - Replaces timer1 or timer2 for serial
module ufbt_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic double_rate_bit,
  input wire logic timer2_transmit_clock_select,
  input wire logic timer2_receive_clock_select,
  input wire logic fixed_rate_mode,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  output logic uart_rate_source_select,
  output logic tx_tick16,
  output logic rx_tick16
);
  ufbt_div_if div_bus ();

  logic [2:0] binary_prescale_exponent;
  logic [5:0] fractional_divide_value;
  logic [1:0] fix_cnt;
  logic t1_half;

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = addr == off;
  endfunction : hit

  // Code 7 is undocumented; treated as the deepest divider
  function automatic logic [ufbt_pkg::ACC_W-1:0] prescale_modulus(
    input logic [2:0] div, input logic [5:0] fd);
    logic [2:0] d;
    d = (div > ufbt_pkg::DIV_MAX) ? ufbt_pkg::DIV_MAX : div;
    prescale_modulus = {6'h00, 1'b1, fd} << d;
  endfunction : prescale_modulus

  logic wr_ctrl;
  logic wr_fd;
  logic [7:0] ctrl_view;
  logic [7:0] fd_view;
  logic [7:0] next_rdata;
  logic fix_tick;
  logic t1_tick;
  logic next_tx;
  logic next_rx;
  logic conv_tx;
  logic conv_rx;

  assign wr_ctrl = sfr_wr && hit(sfr_addr, ufbt_pkg::CTRL_OFF);
  assign wr_fd = sfr_wr && hit(sfr_addr, ufbt_pkg::FD_OFF);

  assign ctrl_view = {uart_rate_source_select, 4'h0,
                      binary_prescale_exponent};
  assign fd_view = {2'h0, fractional_divide_value};
  // Unmapped addresses read zero
  assign next_rdata = !sfr_rd ? 8'h00
                    : hit(sfr_addr, ufbt_pkg::CTRL_OFF) ? ctrl_view
                    : hit(sfr_addr, ufbt_pkg::FD_OFF) ? fd_view
                    : 8'h00;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      uart_rate_source_select <= ufbt_pkg::CTRL_RESET[ufbt_pkg::CTRL_SEL_BIT];
      binary_prescale_exponent <= ufbt_pkg::CTRL_RESET[ufbt_pkg::DIV_W-1:0];
    end
    else if (wr_ctrl)
    begin
      uart_rate_source_select <= sfr_wdata[ufbt_pkg::CTRL_SEL_BIT];
      binary_prescale_exponent <= sfr_wdata[ufbt_pkg::CTRL_DIV_MSB:0];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      fractional_divide_value <= ufbt_pkg::FD_RESET[ufbt_pkg::FD_W-1:0];
    else if (wr_fd)
      fractional_divide_value <= sfr_wdata[ufbt_pkg::FD_MSB:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else
      sfr_rdata <= next_rdata;
  end

  // modulus 2^div*(fd+64) against 64 per clock
  assign div_bus.modulus = prescale_modulus(binary_prescale_exponent,
                                            fractional_divide_value);
  assign div_bus.run = uart_rate_source_select;
  assign div_bus.restart = wr_ctrl || wr_fd;

  ufbt_frac_div u_div (
    .clock(clock),
    .rst(rst),
    .bus(div_bus.div)
  );

  // classic sources kept alive when deselected
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      fix_cnt <= 2'h0;
    else
      fix_cnt <= fix_cnt + 2'h1;
  end

  // Timer1 overflow must be halved when double rate is off
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      t1_half <= 1'b0;
    else if (timer1_overflow)
      t1_half <= !t1_half;
  end

  assign fix_tick = double_rate_bit ? fix_cnt[0]
                                    : (fix_cnt == ufbt_pkg::FIX_LAST);
  assign t1_tick = timer1_overflow && (double_rate_bit || t1_half);
  assign conv_tx = fixed_rate_mode ? fix_tick
                 : timer2_transmit_clock_select ? timer2_overflow : t1_tick;
  assign conv_rx = fixed_rate_mode ? fix_tick
                 : timer2_receive_clock_select ? timer2_overflow : t1_tick;

  // selected path looks at none of the classic controls
  // stands in for timer1 or timer2
  assign next_tx = uart_rate_source_select ? div_bus.tick : conv_tx;
  assign next_rx = uart_rate_source_select ? div_bus.tick : conv_rx;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tx_tick16 <= 1'b0;
      rx_tick16 <= 1'b0;
    end
    else
    begin
      tx_tick16 <= next_tx;
      rx_tick16 <= next_rx;
    end
  end

  // Helper: cycles between selected ticks at the reference setting
  logic [3:0] gap;
  logic armed;
  logic ex_cfg;
  logic restart_d;

  assign ex_cfg = uart_rate_source_select
    && binary_prescale_exponent == ufbt_pkg::EX_DIV
    && fractional_divide_value == ufbt_pkg::EX_FD;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gap <= 4'h0;
    else if (tx_tick16)
      gap <= 4'h0;
    else if (gap != 4'hf)
      gap <= gap + 4'h1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      armed <= 1'b0;
    // Tick already in flight at a restart is stale
    else if (!ex_cfg || div_bus.restart || restart_d)
      armed <= 1'b0;
    else if (tx_tick16)
      armed <= 1'b1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      restart_d <= 1'b0;
    else
      restart_d <= div_bus.restart;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_sel_drives_tick: assert property (
    uart_rate_source_select && !wr_ctrl && div_bus.tick |=> tx_tick16)
    else $error("selected timer tick not forwarded");

  a_ignore_classic: assert property (
    uart_rate_source_select && !div_bus.tick
      && (timer1_overflow || timer2_overflow) |=> !tx_tick16 && !rx_tick16)
    else $error("classic source leaked while selected");

  a_conv_timer2: assert property (
    !uart_rate_source_select && !fixed_rate_mode
      && timer2_transmit_clock_select && timer2_overflow |=> tx_tick16)
    else $error("timer2 tick lost when deselected");

  a_prescale_mod: assert property (
    binary_prescale_exponent == 3'h2 && fractional_divide_value == 6'h00
      |-> div_bus.modulus == 13'h0100)
    else $error("prescale exponent not applied");

  a_frac_store: assert property (
    wr_fd |=> fractional_divide_value == $past(sfr_wdata[5:0]))
    else $error("fraction not stored");

  a_unimpl_zero: assert property (
    sfr_rd |=> sfr_rdata[6:3] == 4'h0
      || !hit($past(sfr_addr), ufbt_pkg::CTRL_OFF))
    else $error("unimplemented control bits read back");

  a_ctrl_reset: assert property (@(posedge clock)
    $past(rst) |-> !uart_rate_source_select
      && binary_prescale_exponent == 3'h0)
    else $error("control not zero after reset");

  a_fd_reset: assert property (@(posedge clock)
    $past(rst) |-> fractional_divide_value == 6'h00)
    else $error("fraction not zero after reset");

  a_ref_spacing: assert property (
    armed && tx_tick16 |-> gap == 4'h2 || gap == 4'h3)
    else $error("reference rate tick spacing wrong");

  a_ref_modulus: assert property (
    ex_cfg |-> div_bus.modulus == ufbt_pkg::EX_MOD)
    else $error("reference modulus wrong");

  a_common_tick: assert property (
    uart_rate_source_select && $past(uart_rate_source_select)
      |-> tx_tick16 == rx_tick16)
    else $error("directions diverge while selected");

  a_rdata_idle: assert property (
    !sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not idle");

  a_fd_unimpl: assert property (
    sfr_rd && hit(sfr_addr, ufbt_pkg::FD_OFF) |=> sfr_rdata[7:6] == 2'h0)
    else $error("unimplemented fraction bits read back");

  a_sel_store: assert property (
    wr_ctrl |=> uart_rate_source_select == $past(sfr_wdata[7]))
    else $error("select bit not stored");

  a_div_store: assert property (
    wr_ctrl |=> binary_prescale_exponent == $past(sfr_wdata[2:0]))
    else $error("prescale exponent not stored");

  a_exp7_clamp: assert property (
    binary_prescale_exponent == 3'h7
      |-> div_bus.modulus == {1'b1, fractional_divide_value, 6'h00})
    else $error("exponent seven not divided as six");

  a_regs_hold: assert property (
    !wr_ctrl && !wr_fd |=> $stable(fractional_divide_value)
      && $stable(binary_prescale_exponent) && $stable(uart_rate_source_select))
    else $error("register changed without a write");

  a_fixed_pair: assert property (
    !uart_rate_source_select && fixed_rate_mode |=> tx_tick16 == rx_tick16)
    else $error("fixed rate directions diverge");

  a_t1_double: assert property (
    !uart_rate_source_select && !fixed_rate_mode && double_rate_bit
      && !timer2_receive_clock_select && timer1_overflow |=> rx_tick16)
    else $error("timer1 tick lost at double rate");

  a_rx_timer2: assert property (
    !uart_rate_source_select && !fixed_rate_mode
      && timer2_receive_clock_select && timer2_overflow |=> rx_tick16)
    else $error("timer2 receive tick lost");

  a_restart_clean: assert property (
    uart_rate_source_select && wr_fd |=> ##1 !tx_tick16)
    else $error("stale tick after fraction write");

  c_ref_rate: cover property (armed && tx_tick16 ##[3:4] tx_tick16);
  c_sel_on: cover property (wr_ctrl && sfr_wdata[7] ##[1:8] tx_tick16);
  c_t1_half: cover property (!uart_rate_source_select
    && timer1_overflow && !double_rate_bit ##1 timer1_overflow);
  c_fixed: cover property (!uart_rate_source_select && fixed_rate_mode
    && tx_tick16);
endmodule : ufbt_top

//--- dv/ufbt_uart_model.sv
module ufbt_uart_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic tx_tick16,
  input wire logic rx_tick16,
  output int tx_count,
  output int rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clock or posedge rst)
  begin
    if (rst || clear)
    begin
      tx_count <= 0;
      rx_count <= 0;
    end
    else
    begin
      tx_count <= tx_count + int'(tx_tick16);
      rx_count <= rx_count + int'(rx_tick16);
    end
  end
endmodule : ufbt_uart_model

//--- dv/uart_fractional_baud_timer_test.sv
module uart_fractional_baud_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0;
  logic rst = 1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 0;
  logic [7:0] sfr_rdata;
  logic dbl = 0;
  logic t2tx = 0;
  logic t2rx = 0;
  logic fixed = 0;
  logic t1ovf = 0;
  logic t2ovf = 0;
  logic sel;
  logic tx_t;
  logic rx_t;
  logic clear = 0;
  logic noise = 0;
  logic rd_seen = 0;
  int tx_count;
  int rx_count;
  int cyc = 0;
  int p1 = 0;
  int p2 = 0;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] exp_q[$];
  ufbt_top DUT (.clock(clock), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .double_rate_bit(dbl),
    .timer2_transmit_clock_select(t2tx),
    .timer2_receive_clock_select(t2rx), .fixed_rate_mode(fixed),
    .timer1_overflow(t1ovf), .timer2_overflow(t2ovf),
    .uart_rate_source_select(sel), .tx_tick16(tx_t), .rx_tick16(rx_t));
  ufbt_uart_model uart (.clock(clock), .rst(rst), .clear(clear),
    .tx_tick16(tx_t), .rx_tick16(rx_t), .tx_count(tx_count),
    .rx_count(rx_count));
  always #10 clock = ~clock;
  // Noise proves ignored inputs, otherwise periodic overflows
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (noise)
      {dbl, t2tx, t2rx, t1ovf, t2ovf} <= 5'($urandom);
    else
    begin
      t1ovf <= (p1 != 0) && (cyc % p1 == 0);
      t2ovf <= (p2 != 0) && (cyc % p2 == 0);
    end
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge clock)
  begin
    rd_seen <= sfr_rd;
    if (rd_seen)
    begin
      checks_done++;
      if (sfr_rdata !== exp_q[0])
      begin
        mismatches++;
        $display("mismatch %0t read %h expected %h", $time, sfr_rdata,
          exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1;
    @(posedge clock);
    sfr_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1;
    exp_q.push_back(e);
    @(posedge clock);
    sfr_rd <= 0;
  endtask : rd
  task automatic check(input int got, input int e, input int tol);
    checks_done++;
    if (got > e + tol || got < e - tol)
    begin
      mismatches++;
      $display("mismatch %0t ticks %0d expected %0d", $time, got, e);
    end
  endtask : check
  // Tolerance of one tick covers window edges
  task automatic count(input int n, input int et, input int er);
    clear <= 1;
    @(posedge clock);
    clear <= 0;
    repeat (n) @(posedge clock);
    check(tx_count, et, 1);
    check(rx_count, er, 1);
  endtask : count
  task automatic rate(input logic [2:0] d, input logic [5:0] f);
    int e;
    e = 2048 * 64 / ((1 << d) * (int'(f) + 64));
    wr(8'h9d, {2'b11, f});
    wr(8'h9e, {5'h1f, d});
    repeat (4) @(posedge clock);
    count(2048, e, e);
    check(int'(sel === 1'b1), 1, 0);
  endtask : rate
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    #1000000;
    mismatches++;
    finish_test();
  end
  initial
  begin
    void'($urandom(32'h65220297));
    repeat (2) @(posedge clock);
    rst <= 0;
    rd(8'h9e, 8'h00);
    rd(8'h9d, 8'h00);
    rd(8'h9c, 8'h00);
    wr(8'h9c, 8'hff);
    rd(8'h9e, 8'h00);
    wr(8'h9e, 8'hff);
    rd(8'h9e, 8'h87);
    wr(8'h9d, 8'hff);
    rd(8'h9d, 8'h3f);
    // Exponent seven divides as six
    count(2048, 16, 16);
    noise <= 1;
    rate(3'h1, 6'h2d);
    repeat (3) rate(3'($urandom % 7), 6'($urandom));
    rate(3'h6, 6'h3f);
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    rd(8'h9e, 8'h00);
    rd(8'h9d, 8'h00);
    check(int'(sel === 1'b0), 1, 0);
    rate(3'h0, 6'h00);
    rate(3'h2, 6'h00);
    noise <= 0;
    wr(8'h9e, 8'h00);
    {dbl, t2tx, t2rx} <= 3'h0;
    fixed <= 1;
    count(400, 100, 100);
    dbl <= 1;
    count(400, 200, 200);
    fixed <= 0;
    p1 <= 5;
    count(400, 80, 80);
    dbl <= 0;
    count(400, 40, 40);
    p1 <= 0;
    p2 <= 3;
    t2tx <= 1;
    count(399, 133, 0);
    p1 <= 5;
    t2tx <= 0;
    t2rx <= 1;
    dbl <= 1;
    count(399, 80, 133);
    check(int'(sel === 1'b0), 1, 0);
    finish_test();
  end
endmodule : uart_fractional_baud_timer_test
